// File: core/ipr_index_port.sv
// Indexed host access path to internal registers and RAM
//
// Operation
// - The index register holds a seven-bit pointer in its low bits that resets to zero.
// - Index bit seven is a read-only busy flag for serial-bus or host-bus occupancy.
// - The busy flag sets on an index-port write and while a serial transaction runs.
// - Index-write busy clears on the next data access; serial busy clears at its end.
// - A data access at index 41h moves the pointer to 42h.
// - A data access at index 43h moves the pointer to 44h.
// - A data access at index 45h moves the pointer to 46h.
// - Data accesses in the self-test store advance the pointer and stop at 1Fh.
// - Data accesses in the upper value RAM advance the pointer and stop at 7Fh.
// - The serial slave address register is at index 48h and resets to 2Dh.
// - The data port reads the selected location and writes bytes into it; 41h, 42h, 49h and 4Ah to 5Fh ignore writes.
// - The capture ports use their own write pointer, apart from the index pointer.
`timescale 1ns/1ns
`include "ipr_defines.svh"
module ipr_index_port #(
    parameter logic [7:0] CHIP_ID = 8'hA5  // Arbitrary identity value
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset,
    input  wire ipr_pkg::ipr_req_t    i_req,
    input  wire logic                 i_serial_active,
    input  wire ipr_pkg::ipr_events_t i_events,
    input  wire logic [3:0]           i_voltage_id_inputs,
    output logic      [7:0]           o_rdata,
    output logic      [7:0]           o_config,
    output logic                      o_busy
);
    import ipr_pkg::*;

    // ======================================================================
    // Access decode
    logic       idx_wr;
    logic       data_wr;
    logic       data_rd;
    logic       data_acc;
    logic       cap_wr;
    logic [6:0] ptr;
    logic [6:0] next_ptr;
    logic       busy_index;
    logic       next_busy_index;
    logic       serial_q;

    always_comb
    begin
        idx_wr   = i_req.wr && (i_req.port == `IPR_PORT_INDEX);
        data_wr  = i_req.wr && (i_req.port == `IPR_PORT_DATA);
        data_rd  = i_req.rd && (i_req.port == `IPR_PORT_DATA);
        data_acc = data_wr || data_rd;
        cap_wr   = i_req.wr && ((i_req.port == `IPR_PORT_CAPTURE_A) ||
                                (i_req.port == `IPR_PORT_CAPTURE_B));
    end

    // ======================================================================
    // Pointer and busy flag
    function automatic logic [6:0] advance(input logic [6:0] p);
        logic [6:0] r;
        r = p;
        if (p == `IPR_IDX_STAT1 || p == `IPR_IDX_MGMT_MASK1 ||
            p == `IPR_IDX_HOST_MASK1)
            r = p + 7'h01;
        else if (p < `IPR_IDX_STORE_LAST)
            r = p + 7'h01;
        else if (p >= `IPR_IDX_VAL_HI_FIRST && p != `IPR_IDX_VAL_HI_LAST)
            r = p + 7'h01;
        return r;
    endfunction

    always_comb
    begin
        next_ptr        = ptr;
        next_busy_index = busy_index;
        if (idx_wr)
        begin
            next_ptr        = i_req.wdata[6:0];
            next_busy_index = 1'b1;
        end
        else if (data_acc)
        begin
            next_ptr        = advance(ptr);
            next_busy_index = 1'b0;
        end
    end

    // Serial activity is a level from the same clock; no synchroniser needed
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            ptr        <= `IPR_PTR_RESET;
            busy_index <= 1'b0;
            serial_q   <= 1'b0;
            o_busy     <= 1'b0;
        end
        else
        begin
            ptr        <= next_ptr;
            busy_index <= next_busy_index;
            serial_q   <= i_serial_active;
            o_busy     <= next_busy_index || i_serial_active;
        end
    end

    // ======================================================================
    // Self-test store with separate capture pointer
    logic [4:0] cap_ptr;
    logic [4:0] next_cap_ptr;
    logic       cap_ovf;
    logic [7:0] store_rd;
    logic       store_we;
    logic [4:0] store_waddr;

    always_comb
    begin
        next_cap_ptr = cap_ptr;
        cap_ovf      = cap_wr && (cap_ptr == `IPR_IDX_STORE_LAST);
        if (cap_wr && !cap_ovf)
            next_cap_ptr = cap_ptr + 5'h01;
        store_we    = cap_wr || (data_wr && ptr <= `IPR_IDX_STORE_LAST);
        store_waddr = cap_wr ? cap_ptr : ptr[4:0];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            cap_ptr <= 5'h00;
        else
            cap_ptr <= next_cap_ptr;
    end

    ipr_byte_ram #(.AW(5)) u_store (
        .i_ref_clk (i_ref_clk),
        .i_we      (store_we),
        .i_waddr   (store_waddr),
        .i_wdata   (i_req.wdata),
        .i_raddr   (ptr[4:0]),
        .o_rdata   (store_rd)
    );

    // ======================================================================
    // Measured-value RAM, both ranges in one array
    logic       in_value;
    logic [7:0] value_rd;

    always_comb
    begin
        in_value = (ptr >= `IPR_IDX_VAL_LO_FIRST && ptr <= `IPR_IDX_VAL_LO_LAST) ||
                   (ptr >= `IPR_IDX_VAL_HI_FIRST);
    end

    ipr_byte_ram #(.AW(6)) u_value (
        .i_ref_clk (i_ref_clk),
        .i_we      (data_wr && in_value),
        .i_waddr   ({ptr[6], ptr[4:0]}),
        .i_wdata   (i_req.wdata),
        .i_raddr   ({ptr[6], ptr[4:0]}),
        .o_rdata   (value_rd)
    );

    // ======================================================================
    // Registers 40h to 49h
    logic       init;
    logic [7:0] cfg;
    logic [7:0] next_cfg;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic [7:0] next_stat1;
    logic [7:0] next_stat2;
    logic [7:0] mgmt1;
    logic [7:0] mgmt2;
    logic [7:0] host1;
    logic [7:0] host2;
    logic [7:0] slave_addr;
    logic [3:0] fan_div;
    logic [3:0] next_fan_div;
    logic [3:0] vid_meta;
    logic [3:0] vid_sync;

    function automatic logic wr_at(input logic w, input logic [6:0] p, input logic [6:0] idx);
        return w && (p == idx);
    endfunction

    always_comb
    begin
        // Init bit restores defaults; self-clears so it never reads back
        init     = wr_at(data_wr, ptr, `IPR_IDX_CONFIG) && i_req.wdata[`IPR_CFG_INIT_BIT];
        next_cfg = cfg;
        if (init)
            next_cfg = `IPR_RST_CONFIG;
        else if (wr_at(data_wr, ptr, `IPR_IDX_CONFIG))
            next_cfg = i_req.wdata;
        // Set wins over read-to-clear so no event is lost
        next_stat1 = (data_rd && ptr == `IPR_IDX_STAT1) ? 8'h00 : stat1;
        next_stat2 = (data_rd && ptr == `IPR_IDX_STAT2) ? 8'h00 : stat2;
        if (init)
        begin
            next_stat1 = 8'h00;
            next_stat2 = 8'h00;
        end
        next_stat1 = next_stat1 | i_events.first;
        next_stat2 = next_stat2 | i_events.second;
        next_stat2[`IPR_STAT2_OVF_BIT]  = next_stat2[`IPR_STAT2_OVF_BIT] | cap_ovf;
        next_stat2[`IPR_STAT2_RSVD_BIT] = 1'b0;
        next_fan_div = fan_div;
        if (init)
            next_fan_div = `IPR_RST_FAN_DIV_HI;
        else if (wr_at(data_wr, ptr, `IPR_IDX_FAN_DIV))
            next_fan_div = i_req.wdata[7:4];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            cfg      <= `IPR_RST_CONFIG;
            o_config <= `IPR_RST_CONFIG;
            stat1    <= `IPR_RST_ZERO;
            stat2    <= `IPR_RST_ZERO;
            fan_div  <= `IPR_RST_FAN_DIV_HI;
            vid_meta <= 4'h0;
            vid_sync <= 4'h0;
        end
        else
        begin
            cfg      <= next_cfg;
            o_config <= next_cfg;
            stat1    <= next_stat1;
            stat2    <= next_stat2;
            fan_div  <= next_fan_div;
            vid_meta <= i_voltage_id_inputs;
            vid_sync <= vid_meta;
        end
    end

    ipr_reg8 #(.RESET_VALUE(`IPR_RST_ZERO)) u_mgmt1 (
        .i_ref_clk (i_ref_clk), .i_reset (i_reset), .i_init (init),
        .i_we (wr_at(data_wr, ptr, `IPR_IDX_MGMT_MASK1)), .i_wdata (i_req.wdata), .o_q (mgmt1));
    ipr_reg8 #(.RESET_VALUE(`IPR_RST_ZERO)) u_mgmt2 (
        .i_ref_clk (i_ref_clk), .i_reset (i_reset), .i_init (init),
        .i_we (wr_at(data_wr, ptr, `IPR_IDX_MGMT_MASK2)), .i_wdata (i_req.wdata), .o_q (mgmt2));
    ipr_reg8 #(.RESET_VALUE(`IPR_RST_ZERO)) u_host1 (
        .i_ref_clk (i_ref_clk), .i_reset (i_reset), .i_init (init),
        .i_we (wr_at(data_wr, ptr, `IPR_IDX_HOST_MASK1)), .i_wdata (i_req.wdata), .o_q (host1));
    ipr_reg8 #(.RESET_VALUE(`IPR_RST_HOST_MASK2)) u_host2 (
        .i_ref_clk (i_ref_clk), .i_reset (i_reset), .i_init (init),
        .i_we (wr_at(data_wr, ptr, `IPR_IDX_HOST_MASK2)), .i_wdata (i_req.wdata), .o_q (host2));
    // Slave address survives init on purpose
    ipr_reg8 #(.RESET_VALUE(`IPR_RST_SLAVE_ADDR)) u_slave (
        .i_ref_clk (i_ref_clk), .i_reset (i_reset), .i_init (1'b0),
        .i_we (wr_at(data_wr, ptr, `IPR_IDX_SLAVE_ADDR)), .i_wdata (i_req.wdata),
        .o_q (slave_addr));

    // ======================================================================
    // Read path
    logic [7:0] sel_data;
    logic [7:0] next_rdata;

    always_comb
    begin
        case (ptr)
            `IPR_IDX_CONFIG:     sel_data = cfg;
            `IPR_IDX_STAT1:      sel_data = stat1;
            `IPR_IDX_STAT2:      sel_data = stat2;
            `IPR_IDX_MGMT_MASK1: sel_data = mgmt1;
            `IPR_IDX_MGMT_MASK2: sel_data = mgmt2;
            `IPR_IDX_HOST_MASK1: sel_data = host1;
            `IPR_IDX_HOST_MASK2: sel_data = host2;
            `IPR_IDX_FAN_DIV:    sel_data = {fan_div, vid_sync};
            `IPR_IDX_SLAVE_ADDR: sel_data = slave_addr;
            `IPR_IDX_CHIP_ID:    sel_data = CHIP_ID;
            default:
                if (ptr <= `IPR_IDX_STORE_LAST)
                    sel_data = store_rd;
                else if (in_value)
                    sel_data = value_rd;
                else
                    sel_data = 8'h00;
        endcase
        next_rdata = o_rdata;
        if (data_rd)
            next_rdata = sel_data;
        else if (i_req.rd && i_req.port == `IPR_PORT_INDEX)
            next_rdata = {busy_index || serial_q, ptr};
        else if (i_req.rd)
            next_rdata = 8'h00;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_rdata <= 8'h00;
        else
            o_rdata <= next_rdata;
    end

    // ======================================================================
    // Checks
    sequence s_data_at(logic [6:0] idx);
        data_acc && !idx_wr && ptr == idx;
    endsequence

    a_ptr_after_reset: assert property (@(posedge i_ref_clk)
        i_reset |=> ptr == 7'h00)
        else $error("pointer not zero after reset");
    a_busy_on_index: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        idx_wr ##1 !data_acc |=> o_busy)
        else $error("busy not set by index write");
    a_busy_on_data: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        data_acc && !i_serial_active |=> !o_busy && !busy_index)
        else $error("busy not cleared by data access");
    a_busy_serial: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_serial_active [*2] |=> o_busy && serial_q)
        else $error("busy not shown during serial transfer");
    a_inc_stat: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        s_data_at(7'h41) |=> ptr == 7'h42)
        else $error("no advance from 41h");
    a_inc_mgmt: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        s_data_at(7'h43) |=> ptr == 7'h44)
        else $error("no advance from 43h");
    a_inc_host: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        s_data_at(7'h45) |=> ptr == 7'h46)
        else $error("no advance from 45h");
    a_store_stop: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        data_acc && !idx_wr && ptr <= 7'h1F |=> ptr == (($past(ptr) == 7'h1F) ?
            7'h1F : $past(ptr) + 7'h01))
        else $error("self-test store pointer wrong");
    a_value_stop: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        data_acc && !idx_wr && ptr >= 7'h60 |=> ptr == (($past(ptr) == 7'h7F) ?
            7'h7F : $past(ptr) + 7'h01))
        else $error("upper value pointer wrong");
    a_hold_plain: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        data_acc && !idx_wr && (ptr == 7'h40 || ptr == 7'h47 || ptr == 7'h49 ||
            (ptr >= 7'h20 && ptr <= 7'h3F)) |=> $stable(ptr))
        else $error("pointer moved at plain index");
    a_slave_reset: assert property (@(posedge i_ref_clk)
        i_reset |=> slave_addr == 8'h2D)
        else $error("slave address reset value wrong");
    a_read_data: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        data_rd ##1 1'b1 |-> o_rdata == $past(sel_data))
        else $error("data port read mismatch");
    a_capture_apart: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        cap_wr |=> $stable(ptr))
        else $error("capture write moved index pointer");
endmodule // ipr_index_port

// File: core/ipr_defines.svh
// Constants of the indexed register port: ports, indices, reset values
`ifndef IPR_DEFINES_SVH
`define IPR_DEFINES_SVH

// ==========================================================================
// Host port offsets (low three address bits)
`define IPR_PORT_CAPTURE_A   3'h0
`define IPR_PORT_CAPTURE_B   3'h4
`define IPR_PORT_INDEX       3'h5
`define IPR_PORT_DATA        3'h6

// ==========================================================================
// Index register fields
`define IPR_BUSY_BIT         7
`define IPR_PTR_RESET        7'h00

// ==========================================================================
// Internal indices
`define IPR_IDX_STORE_LAST   7'h1F
`define IPR_IDX_VAL_LO_FIRST 7'h20
`define IPR_IDX_VAL_LO_LAST  7'h3F
`define IPR_IDX_CONFIG       7'h40
`define IPR_IDX_STAT1        7'h41
`define IPR_IDX_STAT2        7'h42
`define IPR_IDX_MGMT_MASK1   7'h43
`define IPR_IDX_MGMT_MASK2   7'h44
`define IPR_IDX_HOST_MASK1   7'h45
`define IPR_IDX_HOST_MASK2   7'h46
`define IPR_IDX_FAN_DIV      7'h47
`define IPR_IDX_SLAVE_ADDR   7'h48
`define IPR_IDX_CHIP_ID      7'h49
`define IPR_IDX_VAL_HI_FIRST 7'h60
`define IPR_IDX_VAL_HI_LAST  7'h7F

// ==========================================================================
// Reset values and fields
`define IPR_RST_CONFIG       8'h08
`define IPR_RST_ZERO         8'h00
`define IPR_RST_HOST_MASK2   8'h40
`define IPR_RST_FAN_DIV_HI   4'h5
`define IPR_RST_SLAVE_ADDR   8'h2D
`define IPR_CFG_INIT_BIT     7
`define IPR_STAT2_OVF_BIT    5
`define IPR_STAT2_RSVD_BIT   7

`endif

// File: core/ipr_pkg.sv
// Types shared by the indexed register port
package ipr_pkg;

    // ======================================================================
    // Host bus request, one cycle per access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] port;
        logic [7:0] wdata;
    } ipr_req_t;

    // ======================================================================
    // Event inputs setting status bits
    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
    } ipr_events_t;

endpackage

// File: core/ipr_reg8.sv
// Eight-bit control register with reset value and init restore
`timescale 1ns/1ns
module ipr_reg8 #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    input  wire logic       i_init,
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_q
);
    logic [7:0] next_q;

    always_comb
    begin
        next_q = o_q;
        if (i_init)
            next_q = RESET_VALUE;
        else if (i_we)
            next_q = i_wdata;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_q <= RESET_VALUE;
        else
            o_q <= next_q;
    end
endmodule // ipr_reg8

// File: core/ipr_byte_ram.sv
// Byte RAM with one write port and one combinational read port
`timescale 1ns/1ns
module ipr_byte_ram #(
    parameter int AW = 5
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [7:0]    o_rdata
);
    // Contents undefined after power-up, as for any plain RAM
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_ref_clk)
    begin
        if (i_we)
            mem[i_waddr] <= i_wdata;
    end

    always_comb
    begin
        o_rdata = mem[i_raddr];
    end
endmodule // ipr_byte_ram

// File: tb/ipr_serial_master.sv
// Serial-bus master model that occupies the device for a set number of cycles
`timescale 1ns/1ns
module ipr_serial_master (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    input  wire logic       i_start,
    input  wire logic [7:0] i_len,
    output logic            o_active
);
    // ==================================================================
    // Transaction length counter
    logic [7:0] left;

    // Started only while the host side is quiet; no arbitration
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            left <= 8'h00;
        else if (i_start)
            left <= i_len;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end

    assign o_active = (left != 8'h00);
endmodule // ipr_serial_master

// File: tb/indexed_register_port_test.sv
// Self-checking bench for the indexed register port
`timescale 1ns/1ns
`include "ipr_defines.svh"
module indexed_register_port_test;
    import ipr_pkg::*;
    // ==================================================================
    // Signals
    localparam logic [7:0] CHIP_ID = 8'h3C;  // Arbitrary identity value
    logic              i_ref_clk;
    logic              i_reset;
    ipr_req_t          i_req;
    logic              serial_start;
    logic [7:0]        serial_len;
    logic              i_serial_active;
    ipr_events_t       i_events;
    logic [3:0]        i_voltage_id_inputs;
    logic [7:0]        o_rdata;
    logic [7:0]        o_config;
    logic              o_busy;
    int                mismatches;
    int                n_checks;
    int                cycles;
    logic [6:0]        idx;
    logic [6:0]        rst_idx [7] = '{7'h40, 7'h41, 7'h43, 7'h46, 7'h47, 7'h48, 7'h49};
    logic [7:0]        rst_val [7] = '{8'h08, 8'h00, 8'h00, 8'h40, 8'h5A, 8'h2D, CHIP_ID};
    logic [6:0]        fix_idx [6] = '{7'h40, 7'h20, 7'h3F, 7'h47, 7'h48, 7'h49};

    ipr_index_port #(.CHIP_ID(CHIP_ID)) uut (
        .i_ref_clk           (i_ref_clk),
        .i_reset             (i_reset),
        .i_req               (i_req),
        .i_serial_active     (i_serial_active),
        .i_events            (i_events),
        .i_voltage_id_inputs (i_voltage_id_inputs),
        .o_rdata             (o_rdata),
        .o_config            (o_config),
        .o_busy              (o_busy)
    );

    ipr_serial_master u_serial (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_start   (serial_start),
        .i_len     (serial_len),
        .o_active  (i_serial_active)
    );

    // ==================================================================
    // Clock and hang guard
    initial i_ref_clk = 1'b0;
    always #5 i_ref_clk = ~i_ref_clk;

    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    // ==================================================================
    // Access tasks; one idle cycle after each so o_rdata has settled
    task automatic acc(input logic w, input logic [2:0] p, input logic [7:0] d);
        @(negedge i_ref_clk);
        i_req = '{wr: w, rd: !w, port: p, wdata: d};
        @(negedge i_ref_clk);
        i_req = '0;
        @(negedge i_ref_clk);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic seti(input logic [6:0] a);
        acc(1'b1, `IPR_PORT_INDEX, {1'b0, a});
    endtask

    task automatic rdd(input logic [2:0] p, input logic [7:0] e);
        acc(1'b0, p, 8'h00);
        chk(o_rdata, e);
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ==================================================================
    // Main sequence
    initial
    begin
        i_reset = 1'b1;
        i_req = '0;
        serial_start = 1'b0;
        serial_len = 8'h06;
        i_events = '0;
        i_voltage_id_inputs = 4'hA;
        mismatches = 0;
        n_checks = 0;
        cycles = 0;
        repeat (10) @(negedge i_ref_clk);
        i_reset = 1'b0;
        chk(o_config, `IPR_RST_CONFIG);
        chk({7'h00, o_busy}, 8'h00);
        rdd(`IPR_PORT_INDEX, 8'h00);
        for (int k = 0; k < 7; k++)
        begin
            seti(rst_idx[k]);
            rdd(`IPR_PORT_DATA, rst_val[k]);
        end
        // Busy from an index write survives index reads
        seti(7'h44);
        chk({7'h00, o_busy}, 8'h01);
        rdd(`IPR_PORT_INDEX, 8'hC4);
        acc(1'b1, `IPR_PORT_DATA, 8'h5A);
        chk({7'h00, o_busy}, 8'h00);
        rdd(`IPR_PORT_INDEX, 8'h44);
        rdd(`IPR_PORT_DATA, 8'h5A);
        // Paired registers, read and write alike
        for (int k = 0; k < 3; k++)
        begin
            idx = 7'h41 + 7'(2 * k);
            seti(idx);
            acc(k == 1, `IPR_PORT_DATA, 8'h00);
            rdd(`IPR_PORT_INDEX, {1'b0, idx + 7'h01});
        end
        // Top of each advancing range: later writes overwrite the top byte
        for (int k = 0; k < 2; k++)
        begin
            idx = (k == 0) ? 7'h1E : 7'h7E;
            seti(idx);
            acc(1'b1, `IPR_PORT_DATA, 8'hA1);
            acc(1'b1, `IPR_PORT_DATA, 8'hB2);
            acc(1'b1, `IPR_PORT_DATA, 8'hC3);
            rdd(`IPR_PORT_INDEX, {1'b0, idx + 7'h01});
            seti(idx);
            rdd(`IPR_PORT_DATA, 8'hA1);
            rdd(`IPR_PORT_DATA, 8'hC3);
        end
        for (int k = 0; k < 6; k++)
        begin
            seti(fix_idx[k]);
            // Writes on 40h and the RAM entries so that no unknown byte is ever read
            acc(k < 3, `IPR_PORT_DATA, 8'h00);
            rdd(`IPR_PORT_INDEX, {1'b0, fix_idx[k]});
        end
        // Status read clears; events pulse one cycle
        @(negedge i_ref_clk);
        i_events = '{first: 8'h81, second: 8'h10};
        @(negedge i_ref_clk);
        i_events = '0;
        seti(`IPR_IDX_STAT1);
        rdd(`IPR_PORT_DATA, 8'h81);
        rdd(`IPR_PORT_DATA, 8'h10);
        seti(`IPR_IDX_STAT1);
        rdd(`IPR_PORT_DATA, 8'h00);
        // Capture ports keep their own pointer
        seti(7'h05);
        acc(1'b1, `IPR_PORT_CAPTURE_A, 8'hC1);
        acc(1'b1, `IPR_PORT_CAPTURE_B, 8'hC2);
        rdd(`IPR_PORT_INDEX, 8'h85);
        seti(7'h00);
        rdd(`IPR_PORT_DATA, 8'hC1);
        rdd(`IPR_PORT_DATA, 8'hC2);
        // Read-only identity, then init keeps the slave address
        seti(`IPR_IDX_CHIP_ID);
        acc(1'b1, `IPR_PORT_DATA, 8'h00);
        rdd(`IPR_PORT_DATA, CHIP_ID);
        seti(`IPR_IDX_SLAVE_ADDR);
        acc(1'b1, `IPR_PORT_DATA, 8'h33);
        seti(`IPR_IDX_CONFIG);
        acc(1'b1, `IPR_PORT_DATA, 8'h01);
        chk(o_config, 8'h01);
        acc(1'b1, `IPR_PORT_DATA, 8'h80);
        chk(o_config, 8'h08);
        seti(`IPR_IDX_MGMT_MASK2);
        rdd(`IPR_PORT_DATA, 8'h00);
        seti(`IPR_IDX_SLAVE_ADDR);
        rdd(`IPR_PORT_DATA, 8'h33);
        // Serial transaction: host stays off the bus meanwhile
        @(negedge i_ref_clk);
        serial_start = 1'b1;
        @(negedge i_ref_clk);
        serial_start = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        chk({7'h00, o_busy}, 8'h01);
        repeat (8) @(negedge i_ref_clk);
        chk({7'h00, o_busy}, 8'h00);
        print_verdict();
    end
endmodule // indexed_register_port_test
